// [rtl/temp_sensor_config_alarm.sv]
`timescale 1ns/1ps
module temp_sensor_config_alarm #(
    parameter logic [6:0] SLAVE_ADDR     = temp_sensor_pkg::SLAVE_ADDR_DEFAULT,
    parameter int         TIMEOUT_CYCLES = temp_sensor_pkg::TIMEOUT_CYCLES,
    parameter int         CONV_CYCLES    = temp_sensor_pkg::CONV_CYCLES_DEFAULT
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic [15:0] sample_code,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             alarm_output,
    output logic             alarm_output_out,
    output logic             alarm_output_oe,
    output logic             conversion_active
);
    import temp_sensor_pkg::*;

    localparam int TMO_W  = $clog2(TIMEOUT_CYCLES + 1);
    localparam int CONV_W = $clog2(CONV_CYCLES + 1);

    // Registers
    logic [7:0]  config_reg;
    logic [15:0] measured_temperature;
    logic [15:0] release_limit_temperature;
    logic [15:0] alarm_limit_temperature;

    // Pin sampling
    logic [1:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_d;
    logic       sda_d;
    logic       start_cond;
    logic       stop_cond;
    logic       scl_rise;
    logic       scl_fall;

    // Serial slave
    i2c_state_t  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        rw;
    logic        master_nack;
    logic [1:0]  pointer;
    logic        byte_sel;
    logic        wr_strobe;
    logic [7:0]  wr_data;
    logic [1:0]  wr_ptr;
    logic        wr_sel;
    logic        rd_strobe;
    logic [15:0] read_word;
    logic [7:0]  read_byte;
    logic [TMO_W-1:0] tmo_cnt;
    logic        bus_timeout;

    // Conversion and alarm
    logic              conv_busy;
    logic [CONV_W-1:0] conv_cnt;
    logic              conv_format;
    logic              oneshot_conv;
    logic              conv_finish;
    logic              conv_done;
    logic              want_conv;
    logic [15:0]       next_temperature;
    logic              dir_high;
    logic              look_high;
    logic              fault;
    logic              trip;
    logic              cfg_write;
    logic              shutdown_entry;

    // Pointer and byte position after one data byte
    function automatic logic [2:0] advance(input logic [1:0] ptr, input logic sel);
        if (!sel) begin
            advance = {ptr, 1'b1};
        end else if (ptr == PTR_ALARM) begin
            advance = {ptr, 1'b0};
        end else begin
            advance = {ptr + 2'h1, 1'b0};
        end
    endfunction

    pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Previous levels for edge and condition detection
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Bus events
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_rise   = scl_s & ~scl_d;
    assign scl_fall   = ~scl_s & scl_d;

    // Stuck data line watchdog
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tmo_cnt     <= '0;
            bus_timeout <= 1'b0;
        end else begin
            bus_timeout <= 1'b0;
            if (sda_s || config_reg[CFG_TIMEOUT_OFF]) begin
                tmo_cnt <= '0;
            end else if (tmo_cnt == TMO_W'(TIMEOUT_CYCLES)) begin
                bus_timeout <= 1'b1;
                tmo_cnt     <= '0;
            end else begin
                tmo_cnt <= tmo_cnt + 1'b1;
            end
        end
    end

    // Read data selection
    always_comb begin
        unique case (pointer)
            PTR_TEMPERATURE: read_word = measured_temperature;
            PTR_CONFIG:      read_word = {config_reg, config_reg};
            PTR_RELEASE:     read_word = release_limit_temperature;
            PTR_ALARM:       read_word = alarm_limit_temperature;
        endcase
    end

    assign read_byte = byte_sel ? read_word[7:0] : read_word[15:8];

    // Serial slave, independent of shutdown
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state       <= I2C_IDLE;
            bit_cnt     <= 4'h0;
            shreg       <= 8'h00;
            rw          <= 1'b0;
            master_nack <= 1'b0;
            pointer     <= PTR_TEMPERATURE;
            byte_sel    <= 1'b0;
            sda_oe      <= 1'b0;
            wr_strobe   <= 1'b0;
            wr_data     <= 8'h00;
            wr_ptr      <= PTR_TEMPERATURE;
            wr_sel      <= 1'b0;
            rd_strobe   <= 1'b0;
        end else begin
            wr_strobe <= 1'b0;
            rd_strobe <= 1'b0;
            if (bus_timeout) begin
                state  <= I2C_IDLE;
                sda_oe <= 1'b0;
            end else if (start_cond) begin
                state   <= I2C_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (stop_cond) begin
                state  <= I2C_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if ((state == I2C_ADDR || state == I2C_PTR || state == I2C_WDATA)
                    && bit_cnt != BYTE_BITS) begin
                    shreg   <= {shreg[6:0], sda_s};
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (state == I2C_MACK) begin
                    master_nack <= sda_s;
                end
            end else if (scl_fall) begin
                unique case (state)
                    I2C_IDLE: begin
                    end
                    I2C_ADDR: if (bit_cnt == BYTE_BITS) begin
                        bit_cnt <= 4'h0;
                        if (shreg[7:1] == SLAVE_ADDR) begin
                            rw     <= shreg[0];
                            sda_oe <= 1'b1;
                            state  <= I2C_ACK_ADDR;
                        end else begin
                            state <= I2C_IDLE;
                        end
                    end
                    I2C_ACK_ADDR: if (rw) begin
                        shreg     <= read_byte;
                        sda_oe    <= ~read_byte[7];
                        bit_cnt   <= 4'h1;
                        rd_strobe <= 1'b1;
                        state     <= I2C_RDATA;
                    end else begin
                        sda_oe <= 1'b0;
                        state  <= I2C_PTR;
                    end
                    I2C_PTR: if (bit_cnt == BYTE_BITS) begin
                        pointer  <= shreg[1:0];
                        byte_sel <= 1'b0;
                        sda_oe   <= 1'b1;
                        bit_cnt  <= 4'h0;
                        state    <= I2C_ACK_PTR;
                    end
                    I2C_ACK_PTR: begin
                        sda_oe <= 1'b0;
                        state  <= I2C_WDATA;
                    end
                    I2C_WDATA: if (bit_cnt == BYTE_BITS) begin
                        wr_strobe           <= 1'b1;
                        wr_data             <= shreg;
                        wr_ptr              <= pointer;
                        wr_sel              <= byte_sel;
                        {pointer, byte_sel} <= advance(pointer, byte_sel);
                        sda_oe              <= 1'b1;
                        bit_cnt             <= 4'h0;
                        state               <= I2C_ACK_WDATA;
                    end
                    I2C_ACK_WDATA: begin
                        sda_oe <= 1'b0;
                        state  <= I2C_WDATA;
                    end
                    I2C_RDATA: if (bit_cnt == BYTE_BITS) begin
                        sda_oe              <= 1'b0;
                        {pointer, byte_sel} <= advance(pointer, byte_sel);
                        state               <= I2C_MACK;
                    end else begin
                        sda_oe  <= ~shreg[6];
                        shreg   <= {shreg[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    I2C_MACK: if (master_nack) begin
                        state <= I2C_IDLE;
                    end else begin
                        shreg     <= read_byte;
                        sda_oe    <= ~read_byte[7];
                        bit_cnt   <= 4'h1;
                        rd_strobe <= 1'b1;
                        state     <= I2C_RDATA;
                    end
                    default: begin
                        state  <= I2C_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Register write decode
    assign cfg_write      = wr_strobe && (wr_ptr == PTR_CONFIG);
    assign shutdown_entry = cfg_write && wr_data[CFG_SHUTDOWN] && !config_reg[CFG_SHUTDOWN];

    // Configuration and limit registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            config_reg                <= CONFIG_RESET;
            release_limit_temperature <= RELEASE_RESET;
            alarm_limit_temperature   <= ALARM_RESET;
        end else begin
            if (cfg_write) begin
                config_reg[CFG_TIMEOUT_OFF:0] <= wr_data[CFG_TIMEOUT_OFF:0];
                config_reg[CFG_ONE_SHOT] <= (wr_data[CFG_ONE_SHOT]
                                             && config_reg[CFG_SHUTDOWN]
                                             && wr_data[CFG_SHUTDOWN])
                                            || (config_reg[CFG_ONE_SHOT]
                                                && !(conv_finish && oneshot_conv));
            end else if (conv_finish && oneshot_conv) begin
                config_reg[CFG_ONE_SHOT] <= 1'b0;
            end
            if (wr_strobe && wr_ptr == PTR_RELEASE) begin
                if (wr_sel) begin
                    release_limit_temperature[7:0] <= wr_data;
                end else begin
                    release_limit_temperature[15:8] <= wr_data;
                end
            end
            if (wr_strobe && wr_ptr == PTR_ALARM) begin
                if (wr_sel) begin
                    alarm_limit_temperature[7:0] <= wr_data;
                end else begin
                    alarm_limit_temperature[15:8] <= wr_data;
                end
            end
        end
    end

    // Conversion scheduling
    assign want_conv   = !config_reg[CFG_SHUTDOWN] || config_reg[CFG_ONE_SHOT];
    assign conv_finish = conv_busy && (conv_cnt == CONV_W'(CONV_CYCLES - 1));
    assign next_temperature = conv_format ? sample_code - EXT_OFFSET : sample_code;

    // Conversion timer and result capture
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            conv_busy            <= 1'b0;
            conv_cnt             <= '0;
            conv_format          <= 1'b0;
            oneshot_conv         <= 1'b0;
            conv_done            <= 1'b0;
            measured_temperature <= TEMPERATURE_RESET;
        end else begin
            conv_done <= 1'b0;
            if (conv_finish) begin
                conv_busy            <= 1'b0;
                conv_done            <= 1'b1;
                measured_temperature <= next_temperature;
            end else if (conv_busy) begin
                conv_cnt <= conv_cnt + 1'b1;
            end else if (want_conv) begin
                conv_busy    <= 1'b1;
                conv_cnt     <= '0;
                conv_format  <= config_reg[CFG_EXT_FORMAT];
                oneshot_conv <= config_reg[CFG_SHUTDOWN];
            end
        end
    end

    // Fault direction and limit compare
    assign look_high = config_reg[CFG_INT_MODE] ? dir_high : !alarm_output;
    assign fault = look_high
        ? ($signed(measured_temperature) > $signed(alarm_limit_temperature))
        : ($signed(measured_temperature) < $signed(release_limit_temperature));

    fault_queue u_fault_queue (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .evaluate   (conv_done),
        .fault      (fault),
        .queue_code (config_reg[CFG_QUEUE_HI:CFG_QUEUE_LO]),
        .trip       (trip)
    );

    // Alarm state, trip wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            alarm_output <= 1'b0;
            dir_high     <= 1'b1;
        end else if (trip) begin
            if (config_reg[CFG_INT_MODE]) begin
                alarm_output <= 1'b1;
                dir_high     <= !dir_high;
            end else begin
                alarm_output <= look_high;
            end
        end else if (config_reg[CFG_INT_MODE] && (rd_strobe || shutdown_entry)) begin
            alarm_output <= 1'b0;
            if (shutdown_entry) begin
                dir_high <= 1'b1;
            end
        end
    end

    // Open-drain pin drives and the conversion_active output
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            alarm_output_oe   <= 1'b0;
            alarm_output_out  <= 1'b0;
            sda_out           <= 1'b0;
            conversion_active <= 1'b0;
        end else begin
            alarm_output_oe   <= alarm_output ^ config_reg[CFG_POLARITY];
            alarm_output_out  <= 1'b0;
            sda_out           <= 1'b0;
            conversion_active <= conv_busy;
        end
    end
endmodule

// [shared/temp_sensor_pkg.sv]
package temp_sensor_pkg;

    // Register pointer values
    localparam logic [1:0] PTR_TEMPERATURE = 2'h0;
    localparam logic [1:0] PTR_CONFIG      = 2'h1;
    localparam logic [1:0] PTR_RELEASE     = 2'h2;
    localparam logic [1:0] PTR_ALARM       = 2'h3;

    // Configuration field positions
    localparam int CFG_SHUTDOWN    = 0;
    localparam int CFG_INT_MODE    = 1;
    localparam int CFG_POLARITY    = 2;
    localparam int CFG_QUEUE_LO    = 3;
    localparam int CFG_QUEUE_HI    = 4;
    localparam int CFG_EXT_FORMAT  = 5;
    localparam int CFG_TIMEOUT_OFF = 6;
    localparam int CFG_ONE_SHOT    = 7;

    // Power-on register values
    localparam logic [7:0]  CONFIG_RESET      = 8'h00;
    localparam logic [15:0] TEMPERATURE_RESET = 16'h0000;
    localparam logic [15:0] RELEASE_RESET     = 16'h4B00;
    localparam logic [15:0] ALARM_RESET       = 16'h5000;

    // Extended format offset, 64 degrees at 1/256 degree per bit
    localparam logic [15:0] EXT_OFFSET = 16'h4000;

    // Fault queue lengths per code
    localparam logic [2:0] FAULTS_1 = 3'h1;
    localparam logic [2:0] FAULTS_2 = 3'h2;
    localparam logic [2:0] FAULTS_4 = 3'h4;
    localparam logic [2:0] FAULTS_6 = 3'h6;

    // Serial bus framing
    localparam logic [3:0] BYTE_BITS          = 4'h8;
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h48;

    // Timing
    localparam int CLK_HZ              = 20_000_000;
    localparam int TIMEOUT_MS          = 50;
    localparam int TIMEOUT_CYCLES      = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int CONV_CYCLES_DEFAULT = 2000;

    typedef enum logic [3:0] {
        I2C_IDLE      = 4'h0,
        I2C_ADDR      = 4'h1,
        I2C_ACK_ADDR  = 4'h2,
        I2C_PTR       = 4'h3,
        I2C_ACK_PTR   = 4'h4,
        I2C_WDATA     = 4'h5,
        I2C_ACK_WDATA = 4'h6,
        I2C_RDATA     = 4'h7,
        I2C_MACK      = 4'h8
    } i2c_state_t;

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // Two-stage synchroniser, idle bus level is high
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            meta     <= '1;
            sync_out <= '1;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// [rtl/fault_queue.sv]
`timescale 1ns/1ps
module fault_queue (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       evaluate,
    input  wire logic       fault,
    input  wire logic [1:0] queue_code,
    output logic            trip
);
    import temp_sensor_pkg::*;

    logic [2:0] run;
    logic [2:0] next_run;

    // Number of consecutive faults that trips the alarm
    function automatic logic [2:0] faults_needed(input logic [1:0] code);
        unique case (code)
            2'b00: faults_needed = FAULTS_1;
            2'b01: faults_needed = FAULTS_2;
            2'b10: faults_needed = FAULTS_4;
            2'b11: faults_needed = FAULTS_6;
        endcase
    endfunction

    // Trip on the conversion that completes the run
    assign next_run = run + 3'h1;
    assign trip     = evaluate & fault & (next_run >= faults_needed(queue_code));

    // Run length, restarted by a good result or a trip
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            run <= 3'h0;
        end else if (trip) begin
            run <= 3'h0;
        end else if (evaluate) begin
            run <= fault ? next_run : 3'h0;
        end
    end
endmodule

// [tb/temp_sensor_alarm_assertions.sv]
`timescale 1ns/1ps
module temp_sensor_alarm_checker #(
    parameter int CONV_CYCLES = 20
) (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic [15:0] sample_code,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        alarm_output,
    input wire logic        alarm_output_out,
    input wire logic        alarm_output_oe,
    input wire logic        conversion_active
);
    int act_len;
    int since_end;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Conversion length so far and cycles since the last conversion ended
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            act_len   <= 0;
            since_end <= 100;
        end else begin
            act_len   <= conversion_active ? act_len + 1 : 0;
            since_end <= (act_len != 0 && !conversion_active) ? 0
                       : (since_end < 100 ? since_end + 1 : 100);
        end
    end

    // Conversion steps
    sequence s_conv_end;
        $fell(conversion_active);
    endsequence
    sequence s_run_start;
        ##[1:3] conversion_active;
    endsequence

    property p_open_drain;
        !sda_out && !alarm_output_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");

    property p_reset_quiet;
        @(posedge ref_clk) disable iff (1'b0)
        !reset_n |=> !sda_oe && !alarm_output && !alarm_output_oe && !conversion_active;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");

    property p_start_run;
        $rose(reset_n) |-> s_run_start;
    endproperty
    a_start_run: assert property (p_start_run) else $error("no conversion after reset");

    property p_conv_len;
        s_conv_end |-> act_len == CONV_CYCLES;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    property p_alarm_after_conv;
        $rose(alarm_output) |-> since_end < 4 || (!conversion_active && act_len != 0);
    endproperty
    a_alarm_after_conv: assert property (p_alarm_after_conv) else $error("alarm off cycle");

    property p_oe_at_scl_low;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    a_oe_at_scl_low: assert property (p_oe_at_scl_low) else $error("data moved, clock high");

    property p_oe_hold;
        $rose(sda_oe) |=> sda_oe [*3];
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data drive too short");

    property p_pin_cause;
        $changed(alarm_output_oe) |->
            $past(alarm_output) != $past(alarm_output, 2) || $past(sda_oe) || $past(sda_oe, 2);
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("alarm pin moved alone");
endmodule

bind temp_sensor_config_alarm temp_sensor_alarm_checker #(.CONV_CYCLES(CONV_CYCLES)) i_checker (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
    .sample_code(sample_code), .sda_out(sda_out), .sda_oe(sda_oe),
    .alarm_output(alarm_output), .alarm_output_out(alarm_output_out),
    .alarm_output_oe(alarm_output_oe), .conversion_active(conversion_active)
);

// [tb/i2c_master_model.sv]
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic ref_clk,
    input  wire logic dev_sda_oe,
    output logic      scl,
    output logic      sda
);
    logic host_low = 1'b0;

    // Pulled-up data wire, low while either party pulls
    assign sda = !(host_low || dev_sda_oe);

    initial scl = 1'b1;

    // Wait cycles, then step past the edge
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    // Wait, then set both lines
    task automatic step(input int n, input logic s, input logic l);
        w(n);
        scl = s;
        host_low = l;
    endtask

    // Start or repeated start, ends with the clock low
    task automatic start();
        step(4, 1'b0, 1'b0);
        step(4, 1'b1, 1'b0);
        step(8, 1'b1, 1'b1);
        step(8, 1'b0, 1'b1);
    endtask

    // Stop, leaves the bus idle
    task automatic stop();
        step(4, 1'b0, 1'b1);
        step(4, 1'b1, 1'b1);
        step(8, 1'b1, 1'b0);
        w(8);
    endtask

    // One bit: data moves only while the clock is low
    task automatic bit_x(input logic b, output logic s);
        step(4, 1'b0, !b);
        step(4, 1'b1, !b);
        w(8);
        s = sda;
        scl = 1'b0;
    endtask

    // Eight bits and the acknowledge slot, MSB first
    task automatic byte9(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
    endtask
endmodule

// [tb/temp_sensor_config_alarm_bench.sv]
`timescale 1ns/1ps
module temp_sensor_config_alarm_bench;
    import temp_sensor_pkg::*;
    localparam int         CONV = 20;
    localparam int         TMO  = 1000;
    localparam logic [6:0] ADDR = 7'h48;
    logic        ref_clk     = 1'b0;
    logic        reset_n     = 1'b0;
    logic [15:0] sample_code = 16'h1900;
    logic        scl;
    logic        sda;
    logic        sda_oe;
    logic        alarm_output;
    logic        alarm_output_oe;
    logic        conversion_active;
    logic [31:0] rdata;
    int          fail_count  = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    int          n;
    logic [2:0]  qlen [4]    = '{FAULTS_1, FAULTS_2, FAULTS_4, FAULTS_6};
    logic [31:0] pairs [4]   = '{{16'h1900, CONFIG_RESET, CONFIG_RESET},
        {CONFIG_RESET, CONFIG_RESET, RELEASE_RESET}, {RELEASE_RESET, ALARM_RESET},
        {ALARM_RESET, ALARM_RESET}};

    always #25 ref_clk = ~ref_clk;

    temp_sensor_config_alarm #(.SLAVE_ADDR(ADDR), .TIMEOUT_CYCLES(TMO), .CONV_CYCLES(CONV)) i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
        .sample_code(sample_code), .sda_out(), .sda_oe(sda_oe), .alarm_output(alarm_output),
        .alarm_output_out(), .alarm_output_oe(alarm_output_oe),
        .conversion_active(conversion_active)
    );

    i2c_master_model i_master (.ref_clk(ref_clk), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Two-byte register write
    task automatic wr(input logic [1:0] ptr, input logic [15:0] d);
        logic [8:0] q [4];
        i_master.start();
        i_master.byte9({ADDR, 2'b01}, q[0]);
        i_master.byte9({6'h00, ptr, 1'b1}, q[1]);
        i_master.byte9({d[15:8], 1'b1}, q[2]);
        i_master.byte9({d[7:0], 1'b1}, q[3]);
        i_master.stop();
        check("write acknowledge", 32'h0, {28'h0, q[0][0], q[1][0], q[2][0], q[3][0]});
    endtask

    // Four-byte read across the pointer advance
    task automatic rd(input logic [1:0] ptr, output logic [31:0] d);
        logic [8:0] q [7];
        i_master.start();
        i_master.byte9({ADDR, 2'b01}, q[0]);
        i_master.byte9({6'h00, ptr, 1'b1}, q[1]);
        i_master.start();
        i_master.byte9({ADDR, 2'b11}, q[2]);
        for (int i = 0; i < 4; i++) begin
            i_master.byte9({8'hFF, i == 3}, q[3 + i]);
        end
        i_master.stop();
        d = {q[3][8:1], q[4][8:1], q[5][8:1], q[6][8:1]};
        check("read acknowledge", 32'h0, {29'h0, q[0][0], q[1][0], q[2][0]});
    endtask

    // Clock held low past the timeout during a driven zero bit, drive checked against exp
    task automatic hold(input logic exp);
        logic [8:0] q;
        i_master.start();
        i_master.byte9({ADDR, 2'b01}, q);
        i_master.byte9({6'h00, PTR_CONFIG, 1'b1}, q);
        i_master.start();
        i_master.byte9({ADDR, 2'b11}, q);
        i_master.w(TMO + 40);
        check("data line drive", {31'h0, exp}, {31'h0, sda_oe});
        i_master.byte9(9'h1FF, q);
        i_master.stop();
    endtask

    // Wait for a conversion end and let the alarm settle
    task automatic conv_end();
        wait (conversion_active === 1'b1);
        wait (conversion_active === 1'b0);
        i_master.w(4);
    endtask

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            complete_run();
        end
    end

    // Main sequence
    initial begin
        i_master.w(12);
        reset_n = 1'b1;
        wr(PTR_TEMPERATURE, 16'h1234);
        for (int p = 0; p < 4; p++) begin
            rd(p[1:0], rdata);
            check("register pair", pairs[p], rdata);
        end
        wr(PTR_CONFIG, 16'h0420);
        rd(PTR_TEMPERATURE, rdata);
        check("extended pair", {16'h1900 - EXT_OFFSET, 16'h2020}, rdata);
        for (int c = 0; c < 4; c++) begin
            wr(PTR_CONFIG, {11'h000, c[1:0], 3'b000});
            conv_end();
            sample_code = 16'h5100;
            n = 0;
            do begin
                conv_end();
                n++;
            end while (alarm_output !== 1'b1 && n < 8);
            check("faults to trip", {29'h0, qlen[c]}, n);
            check("alarm pin low", 32'h1, {31'h0, alarm_output_oe});
            sample_code = 16'h4A00;
            do conv_end(); while (alarm_output === 1'b1);
            check("alarm released", 32'h0, {31'h0, alarm_output});
        end
        wr(PTR_CONFIG, 16'h0004);
        conv_end();
        check("idle high-polarity pin", 32'h1, {31'h0, alarm_output_oe});
        wr(PTR_CONFIG, 16'h0002);
        sample_code = 16'h5100;
        conv_end();
        conv_end();
        conv_end();
        check("alarm held", 32'h1, {31'h0, alarm_output});
        rd(PTR_ALARM, rdata);
        conv_end();
        check("alarm after read", 32'h0, {31'h0, alarm_output});
        sample_code = 16'h4A00;
        conv_end();
        conv_end();
        check("low crossing", 32'h1, {31'h0, alarm_output});
        rd(PTR_CONFIG, rdata);
        check("alarm after read", 32'h0, {31'h0, alarm_output});
        sample_code = 16'h5100;
        conv_end();
        conv_end();
        check("high crossing", 32'h1, {31'h0, alarm_output});
        sample_code = 16'h4A00;
        wr(PTR_CONFIG, 16'h0303);
        check("alarm at shutdown", 32'h0, {31'h0, alarm_output});
        i_master.w(CONV * 3);
        check("stopped", 32'h0, {31'h0, conversion_active});
        wr(PTR_RELEASE, 16'h1234);
        rd(PTR_RELEASE, rdata);
        check("access in shutdown", {16'h1234, ALARM_RESET}, rdata);
        sample_code = 16'h2000;
        wr(PTR_CONFIG, 16'h8181);
        rd(PTR_TEMPERATURE, rdata);
        check("single conversion", 32'h2000_0101, rdata);
        check("back in shutdown", 32'h0, {31'h0, conversion_active});
        sample_code = 16'h1900;
        wr(PTR_CONFIG, 16'h0080);
        conv_end();
        rd(PTR_TEMPERATURE, rdata);
        check("restart pair", 32'h1900_0000, rdata);
        hold(1'b0);
        wr(PTR_CONFIG, 16'h0040);
        hold(1'b1);
        complete_run();
    end
endmodule
